// File: logic/imcr_defines.vh
// imcr_defines.vh: offsets, bit positions and reset values for the interrupt mask block
// assumes inclusion by bare name from the design files
`ifndef IMCR_DEFINES_VH
`define IMCR_DEFINES_VH
`define IMCR_NSRC 32
`define IMCR_AW 12
// register byte offsets
`define IMCR_OFF_PENDING 12'h10C
`define IMCR_OFF_MASK 12'h110
`define IMCR_OFF_LINES 12'h114
`define IMCR_OFF_ENABLE 12'h120
`define IMCR_OFF_DISABLE 12'h124
`define IMCR_OFF_SCLR 12'h128
`define IMCR_OFF_SSET 12'h12C
`define IMCR_OFF_EOI 12'h130
// line status bit positions
`define IMCR_BIT_FAST 0
`define IMCR_BIT_NORMAL 1
// per-source positions, low half
`define IMCR_SRC_FAST 0
`define IMCR_SRC_SOFT0 1
`define IMCR_SRC_WDOG 2
`define IMCR_SRC_WTIM 3
`define IMCR_SRC_SER0 4
`define IMCR_SRC_SER1 5
`define IMCR_SRC_CAND 6
`define IMCR_SRC_SPI 7
`define IMCR_SRC_CANB 8
`define IMCR_SRC_CANC 9
`define IMCR_SRC_CONV0 10
`define IMCR_SRC_CONV1 11
`define IMCR_SRC_GTAA 12
`define IMCR_SRC_GTAB 13
`define IMCR_SRC_GTAC 14
`define IMCR_SRC_SOFT1 15
// per-source positions, high half
`define IMCR_SRC_SOFT2 16
`define IMCR_SRC_SOFT3 17
`define IMCR_SRC_GTBA 18
`define IMCR_SRC_PWM 19
`define IMCR_SRC_CANA 20
`define IMCR_SRC_UIO 21
`define IMCR_SRC_CAP0 22
`define IMCR_SRC_CAP1 23
`define IMCR_SRC_STA 24
`define IMCR_SRC_STB 25
`define IMCR_SRC_SOFT4 26
`define IMCR_SRC_SOFT5 27
`define IMCR_SRC_EXT0 28
`define IMCR_SRC_EXT1 29
`define IMCR_SRC_SOFT6 30
`define IMCR_SRC_SOFT7 31
// soft request positions: 1,15,16,17,26,27,30,31
`define IMCR_SOFT_MAP 32'hCC038002
`define IMCR_ZERO32 32'h00000000
`define IMCR_MASK_RST 32'h00000000
`define IMCR_RESP_OKAY 2'h0
`define IMCR_RESP_SLVERR 2'h2
`endif

// File: logic/imcr_source_cell.v
// imcr_source_cell.v: one per-source pending/forwarding slice
// assumes the parent gives decoded one-cycle command strobes
`timescale 1ns/1ps
module imcr_source_cell
#(
   parameter IS_SOFT = 1'b0
)
(
   input wire clk,
   input wire rst,
   input wire ce,
   input wire src_in,
   input wire soft_set,
   input wire soft_clr,
   input wire enabled,
   output wire pending,
   output wire fwd
);
   reg soft_r;
   wire soft_nxt;
   // set wins over clear in the same cycle
   assign soft_nxt = IS_SOFT ? (soft_set | (soft_r & ~soft_clr)) : 1'b0;
   // soft request flop
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         soft_r <= 1'b0;
      end
      else if (ce)
      begin
         soft_r <= soft_nxt;
      end
   end
   // pending reflects level of source or soft flop
   assign pending = src_in | soft_r;
   // disabled sources are not forwarded
   assign fwd = pending & enabled;
endmodule // imcr_source_cell

// File: logic/imcr_top.v
// imcr_top.v: mask, line status and command registers of a 32-source interrupt controller
// assumes an AXI4-Lite master on SYS_CLK, and hardware sources synchronous level requests
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "imcr_defines.vh"
// Function
// - low sixteen positions: fast, soft0, soft1, watchdog, timers, serial, can, spi, converters
// - high sixteen positions: soft, timers, pwm, can, user io, capture, external lines
// - mask reads 1 for enabled sources; disabled sources never reach the core
// - line status bit 1 reads the normal request line level
// - line status bit 0 reads the fast request line level; upper bits zero
// - clear command ones clear matching soft requests; zeros do nothing
// - set command ones assert matching soft requests; zeros do nothing
// - pending register reads 1 per source with pending request, same layout
module imcr_top
(
   input wire SYS_CLK,
   input wire RST,
   input wire CE,
   input wire [31:0] SRC_IN,
   output wire CORE_NORMAL_LINE_ACTIVE,
   output wire CORE_FAST_LINE_ACTIVE,
   output wire EOI_PULSE,
   input wire [11:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output wire [1:0] S_AXI_BRESP,
   output wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [11:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0] S_AXI_RRESP,
   output wire S_AXI_RVALID,
   input wire S_AXI_RREADY
);
   reg [11:0] awaddr_r;
   reg aw_have_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg w_have_r;
   reg bvalid_r;
   reg [1:0] bresp_r;
   reg rvalid_r;
   reg [31:0] rdata_r;
   reg [1:0] rresp_r;
   reg [31:0] mask_r;
   reg [31:0] mask_nxt;
   reg normal_r;
   reg fast_r;
   reg eoi_r;
   wire [31:0] pending;
   wire [31:0] fwd;
   wire [31:0] wbyte;
   wire do_write;
   wire wr_enable;
   wire wr_disable;
   wire wr_sclr;
   wire wr_sset;
   wire wr_eoi;
   wire wr_known;
   reg [31:0] rd_val;
   reg rd_ok;
   wire [31:0] src_vec;
   // named source lines; soft positions name the hardware line beside the soft flop
   wire fast_line_source;
   wire soft_request0;
   wire watchdog_source;
   wire watch_timer_source;
   wire serial_port0_source;
   wire serial_port1_source;
   wire can_ctrl_d_source;
   wire spi_source;
   wire can_ctrl_b_source;
   wire can_ctrl_c_source;
   wire converter0_source;
   wire converter1_source;
   wire gp_timer_a_ch_a_source;
   wire gp_timer_a_ch_b_source;
   wire gp_timer_a_ch_c_source;
   wire soft_request1;
   wire soft_request2;
   wire soft_request3;
   wire gp_timer_b_ch_a_source;
   wire pwm_source;
   wire can_ctrl_a_source;
   wire user_io_source;
   wire capture_unit0_source;
   wire capture_unit1_source;
   wire simple_timer_a_source;
   wire simple_timer_b_source;
   wire soft_request4;
   wire soft_request5;
   wire external_line0_source;
   wire external_line1_source;
   wire soft_request6;
   wire soft_request7;

   // address and data channels accepted independently, held until the response
   assign S_AXI_AWREADY = CE & ~aw_have_r & ~bvalid_r; // nothing taken while frozen
   assign S_AXI_WREADY = CE & ~w_have_r & ~bvalid_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_ARREADY = CE & ~rvalid_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   assign do_write = aw_have_r & w_have_r & ~bvalid_r;

   // split the source bus into named lines by position
   assign fast_line_source = SRC_IN[`IMCR_SRC_FAST];
   assign soft_request0 = SRC_IN[`IMCR_SRC_SOFT0];
   assign watchdog_source = SRC_IN[`IMCR_SRC_WDOG];
   assign watch_timer_source = SRC_IN[`IMCR_SRC_WTIM];
   assign serial_port0_source = SRC_IN[`IMCR_SRC_SER0];
   assign serial_port1_source = SRC_IN[`IMCR_SRC_SER1];
   assign can_ctrl_d_source = SRC_IN[`IMCR_SRC_CAND];
   assign spi_source = SRC_IN[`IMCR_SRC_SPI];
   assign can_ctrl_b_source = SRC_IN[`IMCR_SRC_CANB];
   assign can_ctrl_c_source = SRC_IN[`IMCR_SRC_CANC];
   assign converter0_source = SRC_IN[`IMCR_SRC_CONV0];
   assign converter1_source = SRC_IN[`IMCR_SRC_CONV1];
   assign gp_timer_a_ch_a_source = SRC_IN[`IMCR_SRC_GTAA];
   assign gp_timer_a_ch_b_source = SRC_IN[`IMCR_SRC_GTAB];
   assign gp_timer_a_ch_c_source = SRC_IN[`IMCR_SRC_GTAC];
   assign soft_request1 = SRC_IN[`IMCR_SRC_SOFT1];
   assign soft_request2 = SRC_IN[`IMCR_SRC_SOFT2];
   assign soft_request3 = SRC_IN[`IMCR_SRC_SOFT3];
   assign gp_timer_b_ch_a_source = SRC_IN[`IMCR_SRC_GTBA];
   assign pwm_source = SRC_IN[`IMCR_SRC_PWM];
   assign can_ctrl_a_source = SRC_IN[`IMCR_SRC_CANA];
   assign user_io_source = SRC_IN[`IMCR_SRC_UIO];
   assign capture_unit0_source = SRC_IN[`IMCR_SRC_CAP0];
   assign capture_unit1_source = SRC_IN[`IMCR_SRC_CAP1];
   assign simple_timer_a_source = SRC_IN[`IMCR_SRC_STA];
   assign simple_timer_b_source = SRC_IN[`IMCR_SRC_STB];
   assign soft_request4 = SRC_IN[`IMCR_SRC_SOFT4];
   assign soft_request5 = SRC_IN[`IMCR_SRC_SOFT5];
   assign external_line0_source = SRC_IN[`IMCR_SRC_EXT0];
   assign external_line1_source = SRC_IN[`IMCR_SRC_EXT1];
   assign soft_request6 = SRC_IN[`IMCR_SRC_SOFT6];
   assign soft_request7 = SRC_IN[`IMCR_SRC_SOFT7];

   // regather the named lines into the per-source vector the slices use
   assign src_vec[`IMCR_SRC_FAST] = fast_line_source;
   assign src_vec[`IMCR_SRC_SOFT0] = soft_request0;
   assign src_vec[`IMCR_SRC_WDOG] = watchdog_source;
   assign src_vec[`IMCR_SRC_WTIM] = watch_timer_source;
   assign src_vec[`IMCR_SRC_SER0] = serial_port0_source;
   assign src_vec[`IMCR_SRC_SER1] = serial_port1_source;
   assign src_vec[`IMCR_SRC_CAND] = can_ctrl_d_source;
   assign src_vec[`IMCR_SRC_SPI] = spi_source;
   assign src_vec[`IMCR_SRC_CANB] = can_ctrl_b_source;
   assign src_vec[`IMCR_SRC_CANC] = can_ctrl_c_source;
   assign src_vec[`IMCR_SRC_CONV0] = converter0_source;
   assign src_vec[`IMCR_SRC_CONV1] = converter1_source;
   assign src_vec[`IMCR_SRC_GTAA] = gp_timer_a_ch_a_source;
   assign src_vec[`IMCR_SRC_GTAB] = gp_timer_a_ch_b_source;
   assign src_vec[`IMCR_SRC_GTAC] = gp_timer_a_ch_c_source;
   assign src_vec[`IMCR_SRC_SOFT1] = soft_request1;
   assign src_vec[`IMCR_SRC_SOFT2] = soft_request2;
   assign src_vec[`IMCR_SRC_SOFT3] = soft_request3;
   assign src_vec[`IMCR_SRC_GTBA] = gp_timer_b_ch_a_source;
   assign src_vec[`IMCR_SRC_PWM] = pwm_source;
   assign src_vec[`IMCR_SRC_CANA] = can_ctrl_a_source;
   assign src_vec[`IMCR_SRC_UIO] = user_io_source;
   assign src_vec[`IMCR_SRC_CAP0] = capture_unit0_source;
   assign src_vec[`IMCR_SRC_CAP1] = capture_unit1_source;
   assign src_vec[`IMCR_SRC_STA] = simple_timer_a_source;
   assign src_vec[`IMCR_SRC_STB] = simple_timer_b_source;
   assign src_vec[`IMCR_SRC_SOFT4] = soft_request4;
   assign src_vec[`IMCR_SRC_SOFT5] = soft_request5;
   assign src_vec[`IMCR_SRC_EXT0] = external_line0_source;
   assign src_vec[`IMCR_SRC_EXT1] = external_line1_source;
   assign src_vec[`IMCR_SRC_SOFT6] = soft_request6;
   assign src_vec[`IMCR_SRC_SOFT7] = soft_request7;

   // byte lanes: only strobed bytes carry command ones
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb = gb + 1)
      begin : g_lane
         assign wbyte[gb*8+7:gb*8] = wstrb_r[gb] ? wdata_r[gb*8+7:gb*8] : 8'h00;
      end
   endgenerate

   // write decode
   assign wr_enable = do_write & (awaddr_r == `IMCR_OFF_ENABLE);
   assign wr_disable = do_write & (awaddr_r == `IMCR_OFF_DISABLE);
   assign wr_sclr = do_write & (awaddr_r == `IMCR_OFF_SCLR);
   assign wr_sset = do_write & (awaddr_r == `IMCR_OFF_SSET);
   assign wr_eoi = do_write & (awaddr_r == `IMCR_OFF_EOI);
   assign wr_known = wr_enable | wr_disable | wr_sclr | wr_sset | wr_eoi;

   // write channel capture and response
   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         awaddr_r <= 12'h000;
         aw_have_r <= 1'b0;
         wdata_r <= `IMCR_ZERO32;
         wstrb_r <= 4'h0;
         w_have_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `IMCR_RESP_OKAY;
      end
      else if (CE)
      begin
         if (S_AXI_AWVALID & S_AXI_AWREADY)
         begin
            awaddr_r <= {S_AXI_AWADDR[11:2], 2'h0};
            aw_have_r <= 1'b1;
         end
         if (S_AXI_WVALID & S_AXI_WREADY)
         begin
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
            w_have_r <= 1'b1;
         end
         if (do_write)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_known ? `IMCR_RESP_OKAY : `IMCR_RESP_SLVERR;
         end
         else if (bvalid_r & S_AXI_BREADY)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // mask next value: disable applied after enable so a bit in both ends cleared
   always @*
   begin
      mask_nxt = mask_r;
      if (wr_enable)
      begin
         mask_nxt = mask_r | wbyte;
      end
      if (wr_disable)
      begin
         mask_nxt = mask_r & ~wbyte;
      end
   end

   // mask register and core line flops
   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         mask_r <= `IMCR_MASK_RST;
         normal_r <= 1'b0;
         fast_r <= 1'b0;
         eoi_r <= 1'b0;
      end
      else if (CE)
      begin
         mask_r <= mask_nxt;
         fast_r <= fwd[`IMCR_SRC_FAST];
         normal_r <= |(fwd & ~(32'h00000001 << `IMCR_SRC_FAST));
         eoi_r <= wr_eoi;
      end
   end

   // one slice per source; soft positions carry a set/clear flop
   genvar gs;
   generate
      for (gs = 0; gs < `IMCR_NSRC; gs = gs + 1)
      begin : g_src
         imcr_source_cell #(
            .IS_SOFT(((`IMCR_SOFT_MAP >> gs) & 32'h00000001) != 32'h00000000)
         ) u_cell (
            .clk(SYS_CLK),
            .rst(RST),
            .ce(CE),
            .src_in(src_vec[gs]),
            .soft_set(wr_sset & wbyte[gs]),
            .soft_clr(wr_sclr & wbyte[gs]),
            .enabled(mask_r[gs]),
            .pending(pending[gs]),
            .fwd(fwd[gs])
         );
      end
   endgenerate

   // read decode
   always @*
   begin
      rd_val = `IMCR_ZERO32;
      rd_ok = 1'b1;
      if ({S_AXI_ARADDR[11:2], 2'h0} == `IMCR_OFF_MASK)
      begin
         rd_val = mask_r;
      end
      else if ({S_AXI_ARADDR[11:2], 2'h0} == `IMCR_OFF_LINES)
      begin
         rd_val[`IMCR_BIT_NORMAL] = normal_r;
         rd_val[`IMCR_BIT_FAST] = fast_r;
      end
      else if ({S_AXI_ARADDR[11:2], 2'h0} == `IMCR_OFF_PENDING)
      begin
         rd_val = pending;
      end
      else if (({S_AXI_ARADDR[11:2], 2'h0} == `IMCR_OFF_ENABLE) ||
               ({S_AXI_ARADDR[11:2], 2'h0} == `IMCR_OFF_DISABLE) ||
               ({S_AXI_ARADDR[11:2], 2'h0} == `IMCR_OFF_SCLR) ||
               ({S_AXI_ARADDR[11:2], 2'h0} == `IMCR_OFF_SSET) ||
               ({S_AXI_ARADDR[11:2], 2'h0} == `IMCR_OFF_EOI))
      begin
         rd_val = `IMCR_ZERO32; // write-only, reads zero
      end
      else
      begin
         rd_ok = 1'b0;
      end
   end

   // read channel
   always @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= `IMCR_ZERO32;
         rresp_r <= `IMCR_RESP_OKAY;
      end
      else if (CE)
      begin
         if (S_AXI_ARVALID & S_AXI_ARREADY)
         begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_ok ? `IMCR_RESP_OKAY : `IMCR_RESP_SLVERR;
         end
         else if (rvalid_r & S_AXI_RREADY)
         begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // core lines come from flops
   assign CORE_NORMAL_LINE_ACTIVE = normal_r;
   assign CORE_FAST_LINE_ACTIVE = fast_r;
   assign EOI_PULSE = eoi_r;
endmodule // imcr_top

// File: tb/imcr_core_model.sv
// imcr_core_model.sv: core side counting requests taken on each line
// assumes level request lines sampled on the system clock
`timescale 1ns/1ps
module imcr_core_model
(
   input wire clk,
   input wire rst,
   input wire [1:0] lines,
   output reg [15:0] cnt_r
);
   reg [1:0] last_r;
   // a rising line is one entry into its handler: normal in the high byte
   always @(posedge clk or posedge rst)
      if (rst)
      begin
         last_r <= 2'h0;
         cnt_r <= 16'h0;
      end
      else
      begin
         last_r <= lines;
         cnt_r <= cnt_r + {7'h0, lines[1] & ~last_r[1], 7'h0, lines[0] & ~last_r[0]};
      end
endmodule // imcr_core_model

// File: tb/imcr_monitor.sv
// imcr_monitor.sv: port assertions for the interrupt mask block
// assumes it is bound onto imcr_top, single clock SYS_CLK
`timescale 1ns/1ps
module imcr_monitor
(
   input wire SYS_CLK,
   input wire RST,
   input wire CE,
   input wire [31:0] SRC_IN,
   input wire CORE_FAST_LINE_ACTIVE,
   input wire CORE_NORMAL_LINE_ACTIVE,
   input wire EOI_PULSE,
   input wire S_AXI_AWREADY,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY
);
   // all checks on the system clock, off during reset
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write answer dropped");
   a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
      && $stable(S_AXI_RDATA)) else $error("read answer moved");
   a_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY) else $error("awready");
   a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("arready");
   a_ar_back: assert property ($fell(S_AXI_RVALID) && CE |-> S_AXI_ARREADY)
      else $error("arready");
   a_fast_cause: assert property (
      CORE_FAST_LINE_ACTIVE && $past(CE) |-> $past(SRC_IN[0])) else $error("fast line");
   a_eoi_single: assert property (EOI_PULSE |=> !EOI_PULSE) else $error("eoi");
   a_lines_frozen: assert property (!CE |=> $stable({CORE_FAST_LINE_ACTIVE,
      CORE_NORMAL_LINE_ACTIVE})) else $error("lines moved while frozen");
endmodule // imcr_monitor
bind imcr_top imcr_monitor imcr_monitor_i (.SYS_CLK, .RST, .CE, .SRC_IN,
   .CORE_FAST_LINE_ACTIVE, .CORE_NORMAL_LINE_ACTIVE, .EOI_PULSE, .S_AXI_AWREADY,
   .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
   .S_AXI_RREADY);

// File: tb/imcr_top_tb.sv
// imcr_top_tb.sv: table-driven bench for the mask and command block
// assumes design, core model and monitor are compiled first
`timescale 1ns/1ps
module imcr_top_tb;
   typedef struct packed {bit w; logic [11:0] a; logic [31:0] v; logic [1:0] r;} imcr_row_t;
   // write rows send v, read rows expect v; r is the expected response
   imcr_row_t rows [0:14] = '{'{1'b0, 12'h110, 32'h0, 2'h0},
      '{1'b1, 12'h120, 32'hFFFFFFFF, 2'h0}, '{1'b1, 12'h124, 32'h0F00F000, 2'h0},
      '{1'b0, 12'h110, 32'hF0FF0FFF, 2'h0}, '{1'b1, 12'h110, 32'hFFFFFFFF, 2'h2},
      '{1'b0, 12'h110, 32'hF0FF0FFF, 2'h0}, '{1'b0, 12'h120, 32'h0, 2'h0},
      '{1'b0, 12'h200, 32'h0, 2'h2}, '{1'b1, 12'h12C, 32'hCC038006, 2'h0},
      '{1'b0, 12'h10C, 32'hCC038002, 2'h0}, '{1'b0, 12'h114, 32'h2, 2'h0},
      '{1'b1, 12'h128, 32'hCC030002, 2'h0}, '{1'b0, 12'h10C, 32'h8000, 2'h0},
      '{1'b0, 12'h114, 32'h0, 2'h0}, '{1'b1, 12'h130, 32'h0, 2'h0}};
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, awv = 1'b0, wv = 1'b0;
   logic arv = 1'b0, bry = 1'b0, rry = 1'b0;
   logic [11:0] adr = 12'h0;
   logic [31:0] src = 32'h0, wd = 32'h0, q;
   logic [1:0] r;
   logic [4:0] h;
   wire awr, wrd, bv, arr, rv, nl, fl, eoi;
   wire [1:0] br, rr;
   wire [31:0] rd;
   wire [15:0] cnt;
   int err_count = 0, checks_done = 0, eoi_n = 0;
   initial forever #5 clk = ~clk;
   imcr_top imcr_top_i (.SYS_CLK(clk), .RST(rst), .CE(ce), .SRC_IN(src),
      .CORE_NORMAL_LINE_ACTIVE(nl), .CORE_FAST_LINE_ACTIVE(fl), .EOI_PULSE(eoi),
      .S_AXI_AWADDR(adr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(adr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rry));
   imcr_core_model imcr_core_model_i (.clk(clk), .rst(rst), .lines({nl, fl}), .cnt_r(cnt));
   // count end-of-interrupt pulses
   always @(posedge clk) if (eoi === 1'b1) eoi_n++;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         $display("unexpected %s: expected %h, seen %h", n, e, s);
         err_count++;
      end
   endtask
   task finish_test;
      if (err_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one bus transfer; the answer is accepted late so the slave must hold it
   task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      awv <= w;
      wv <= w;
      arv <= !w;
      for (int t = 0; t < 200; t++)
      begin
         @(negedge clk);
         h = {awv & awr, wv & wrd, arv & arr, bry & bv, rry & rv};
         q = rd;
         r = w ? br : rr;
         @(posedge clk);
         if (h[4]) awv <= 1'b0;
         if (h[3]) wv <= 1'b0;
         if (h[2]) arv <= 1'b0;
         bry <= w && !h[1] && t > 2;
         rry <= !w && !h[0] && t > 2;
         if (h[1] || h[0]) return;
      end
      err_count++;
      finish_test();
   endtask
   // table rows, then fast line, frozen enable and a second reset
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i])
      begin
         xfer(rows[i].w, rows[i].a, rows[i].v);
         chk("resp", {30'h0, r}, {30'h0, rows[i].r});
         if (!rows[i].w)
            chk("rdata", q, rows[i].v);
      end
      chk("eoi", eoi_n, 32'h1);
      @(posedge clk) src <= 32'h1;
      xfer(1'b0, 12'h114, 32'h0);
      chk("lines", q, 32'h1);
      @(posedge clk) ce <= 1'b0;
      src <= 32'h0;
      repeat (3) @(negedge clk);
      chk("frozen", {31'h0, fl}, 32'h1);
      @(posedge clk) ce <= 1'b1;
      repeat (3) @(negedge clk);
      chk("fast off", {31'h0, fl}, 32'h0);
      @(posedge clk) src <= 32'h1;
      xfer(1'b1, 12'h124, 32'h1);
      repeat (3) @(negedge clk);
      chk("disabled", {31'h0, fl}, 32'h0);
      chk("core", {16'h0, cnt}, 32'h0102);
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      xfer(1'b0, 12'h110, 32'h0);
      chk("mask", q, 32'h0);
      finish_test();
   end
endmodule // imcr_top_tb
